// file: core/gpps_consts.svh
// Notes on behaviour
// (RULE1) Each port has direction, pin-level and output-latch registers.
// (RULE2) Small package has port A only; large package adds port C.
// (RULE3) Writing the latch register equals writing the pin-level register.
// (RULE4) Latch reads return stored values; pin-level reads return pin states.
// (RULE5) Analog-select bit turns the digital input buffer off.
// (RULE6) A pin carrying an enabled peripheral output is not plain GPIO.
// (RULE7) Steering never alters direction; overrides follow the function.
// (RULE8) Steering register bit 4 is unimplemented and reads zero.
// (RULE9) Timer gate input comes from pin A4 when clear, A3 when set.
// (RULE10) Small package: PWM B on pin A4 when set, A0 when clear.
// (RULE11) Large package: PWM B fixed on C4, capture/PWM A fixed on C5.
// (RULE12) Port A is six bits wide, each bit with its own direction.
// (RULE13) Direction one turns driver off; zero drives the latch value.
// (RULE14) Pin A3 is input only; direction reads one, never drives.
// (RULE15) Port writes are read-modify-write into the output latch.
// (RULE16) Direction bits still control drivers on analog pins.
// (RULE17) Software keeps analog pins set as inputs.
// (RULE18) Analog-selected pins read zero in the pin-level register.
// (RULE19) Analog select does not stop digital output driving.
// (RULE20) Software clears analog select before digital input use.
// (RULE21) Several outputs on one pin: the highest priority one wins.
// (RULE22) Weak pull-up is off whenever the pin is an output.
// (RULE23) After reset all direction bits are set, drivers off.
// (RULE24) Unimplemented bits read zero and ignore writes.
`ifndef GPPS_CONSTS_SVH
`define GPPS_CONSTS_SVH

`define GPPS_PW          6 // RULE12
`define GPPS_ADR_A_LEVEL 8'h00
`define GPPS_ADR_A_LATCH 8'h04
`define GPPS_ADR_A_DIR   8'h08
`define GPPS_ADR_A_ANSEL 8'h0C
`define GPPS_ADR_A_PULL  8'h10
`define GPPS_ADR_APF     8'h14
`define GPPS_ADR_C_LEVEL 8'h18
`define GPPS_ADR_C_LATCH 8'h1C
`define GPPS_ADR_C_DIR   8'h20

`define GPPS_DIR_RST     6'h3F
`define GPPS_LAT_RST     6'h00
`define GPPS_ANS_RST     6'h17
`define GPPS_WPU_RST     6'h3F
`define GPPS_APF_RST     8'h00

`define GPPS_DIR_A_MASK  6'h37
`define GPPS_DIR_A_FIXED 6'h08
`define GPPS_LAT_A_MASK  6'h37
`define GPPS_ANS_A_MASK  6'h17
`define GPPS_WPU_MASK    6'h3F
`define GPPS_C_MASK      6'h3F
`define GPPS_APF_MASK    8'hEF

`define GPPS_APF_RX      7
`define GPPS_APF_SDO     6
`define GPPS_APF_SS      5
`define GPPS_APF_GATE    3
`define GPPS_APF_TX      2
`define GPPS_APF_PWMB    1
`define GPPS_APF_CCPA    0

`define GPPS_P0          0
`define GPPS_P1          1
`define GPPS_P2          2
`define GPPS_P3          3
`define GPPS_P4          4
`define GPPS_P5          5

`endif

// file: core/gpps_pkg.sv
`default_nettype none
`include "gpps_consts.svh"
package gpps_pkg;
  typedef struct packed {
    logic [`GPPS_PW-1:0] dir_a;
    logic [`GPPS_PW-1:0] lat_a;
    logic [`GPPS_PW-1:0] ans_a;
    logic [`GPPS_PW-1:0] wpu_a;
    logic [`GPPS_PW-1:0] dir_c;
    logic [`GPPS_PW-1:0] lat_c;
    logic [7:0]          apf;
    logic                ack;
    logic [7:0]          rdat;
  } gpps_state_t;

  typedef enum {
    GPPS_R_A_LEVEL, GPPS_R_A_LATCH, GPPS_R_A_DIR, GPPS_R_A_ANSEL,
    GPPS_R_A_PULL, GPPS_R_APF, GPPS_R_C_LEVEL, GPPS_R_C_LATCH,
    GPPS_R_C_DIR, GPPS_R_NONE
  } gpps_reg_t;
endpackage
`default_nettype wire

// file: core/gpps_sync.sv
`default_nettype none
module gpps_sync #(
  parameter int W = 6
) (
  input  wire logic         clk_i,  // System clock
  input  wire logic         rst_i,  // Synchronous reset
  input  wire logic         ce_i,   // Clock enable
  input  wire logic [W-1:0] d_i,    // Asynchronous pin levels
  output logic      [W-1:0] q_o     // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } gpps_sync_t;

  gpps_sync_t st_r;
  gpps_sync_t st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule
`default_nettype wire

// file: core/gpps_pin_mux.sv
`default_nettype none
`include "gpps_consts.svh"
module gpps_pin_mux #(
  parameter bit LARGE_PKG = 1'b0
) (
  input  wire logic [7:0]          apf_i,    // Steering register
  input  wire logic                tx_d_i,   // Serial tx data
  input  wire logic                tx_en_i,  // Serial tx enabled
  input  wire logic                sdo_d_i,  // SPI data out
  input  wire logic                sdo_en_i, // SPI data out enabled
  input  wire logic                pwmb_d_i, // PWM B data
  input  wire logic                pwmb_en_i,// PWM B enabled
  input  wire logic                ccpa_d_i, // Capture/PWM A data
  input  wire logic                ccpa_en_i,// Capture/PWM A enabled
  input  wire logic [`GPPS_PW-1:0] lvl_a_i,  // Port A digital levels
  input  wire logic [`GPPS_PW-1:0] lvl_c_i,  // Port C digital levels
  output logic      [`GPPS_PW-1:0] ovr_a_o,  // Port A override taken
  output logic      [`GPPS_PW-1:0] val_a_o,  // Port A override value
  output logic      [`GPPS_PW-1:0] ovr_c_o,  // Port C override taken
  output logic      [`GPPS_PW-1:0] val_c_o,  // Port C override value
  output logic                     gate_o,   // Timer gate input
  output logic                     rx_o,     // Serial rx input
  output logic                     ss_o      // Slave select input
);
  // Lowest priority applied first so that higher ones overwrite
  always_comb begin
    ovr_a_o = '0;
    val_a_o = '0;
    ovr_c_o = '0;
    val_c_o = '0;
    if (ccpa_en_i) begin
      if (LARGE_PKG) begin
        ovr_c_o[`GPPS_P5] = 1'b1; // RULE11
        val_c_o[`GPPS_P5] = ccpa_d_i;
      end else if (apf_i[`GPPS_APF_CCPA]) begin
        ovr_a_o[`GPPS_P5] = 1'b1;
        val_a_o[`GPPS_P5] = ccpa_d_i;
      end else begin
        ovr_a_o[`GPPS_P2] = 1'b1;
        val_a_o[`GPPS_P2] = ccpa_d_i;
      end
    end
    if (pwmb_en_i) begin
      if (LARGE_PKG) begin
        ovr_c_o[`GPPS_P4] = 1'b1; // RULE11
        val_c_o[`GPPS_P4] = pwmb_d_i;
      end else if (apf_i[`GPPS_APF_PWMB]) begin
        ovr_a_o[`GPPS_P4] = 1'b1; // RULE10
        val_a_o[`GPPS_P4] = pwmb_d_i;
      end else begin
        ovr_a_o[`GPPS_P0] = 1'b1; // RULE10
        val_a_o[`GPPS_P0] = pwmb_d_i;
      end
    end
    if (sdo_en_i) begin
      if (apf_i[`GPPS_APF_SDO]) begin
        ovr_a_o[`GPPS_P4] = 1'b1; // RULE21
        val_a_o[`GPPS_P4] = sdo_d_i;
      end else if (LARGE_PKG) begin
        ovr_c_o[`GPPS_P2] = 1'b1;
        val_c_o[`GPPS_P2] = sdo_d_i;
      end else begin
        ovr_a_o[`GPPS_P0] = 1'b1; // RULE21
        val_a_o[`GPPS_P0] = sdo_d_i;
      end
    end
    if (tx_en_i) begin
      if (LARGE_PKG && !apf_i[`GPPS_APF_TX]) begin
        ovr_c_o[`GPPS_P4] = 1'b1; // RULE21
        val_c_o[`GPPS_P4] = tx_d_i;
      end else if (!LARGE_PKG && apf_i[`GPPS_APF_TX]) begin
        ovr_a_o[`GPPS_P4] = 1'b1; // RULE21
        val_a_o[`GPPS_P4] = tx_d_i;
      end else begin
        ovr_a_o[`GPPS_P0] = 1'b1; // RULE21
        val_a_o[`GPPS_P0] = tx_d_i;
      end
    end
  end

  // Inputs read the analog-masked levels, so an analog pin gives zero
  assign gate_o = apf_i[`GPPS_APF_GATE] ? lvl_a_i[`GPPS_P3]
                                        : lvl_a_i[`GPPS_P4]; // RULE9
  assign rx_o  = LARGE_PKG
    ? (apf_i[`GPPS_APF_RX] ? lvl_a_i[`GPPS_P1] : lvl_c_i[`GPPS_P5])
    : (apf_i[`GPPS_APF_RX] ? lvl_a_i[`GPPS_P5] : lvl_a_i[`GPPS_P1]);
  assign ss_o  = LARGE_PKG
    ? (apf_i[`GPPS_APF_SS] ? lvl_a_i[`GPPS_P3] : lvl_c_i[`GPPS_P3])
    : (apf_i[`GPPS_APF_SS] ? lvl_a_i[`GPPS_P0] : lvl_a_i[`GPPS_P3]);
endmodule
`default_nettype wire

// file: core/gpps_port.sv
`default_nettype none
`include "gpps_consts.svh"
module gpps_port
  import gpps_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b0   // One adds port C
) (
  input  wire logic                clk_i,        // System clock
  input  wire logic                rst_i,        // Synchronous reset
  input  wire logic                ce_i,         // Clock enable
  input  wire logic                wb_cyc_i,     // Wishbone cycle
  input  wire logic                wb_stb_i,     // Wishbone strobe
  input  wire logic                wb_we_i,      // Wishbone write
  input  wire logic [7:0]          wb_adr_i,     // Byte address
  input  wire logic [3:0]          wb_sel_i,     // Byte selects
  input  wire logic [31:0]         wb_dat_i,     // Write data
  output logic      [31:0]         wb_dat_o,     // Read data
  output logic                     wb_ack_o,     // Acknowledge
  input  wire logic [`GPPS_PW-1:0] pa_in_i,      // Port A pin levels
  output logic      [`GPPS_PW-1:0] pa_out_o,     // Port A output value
  output logic      [`GPPS_PW-1:0] pa_oe_o,      // Port A drive enable
  output logic      [`GPPS_PW-1:0] pa_pullup_o,  // Port A pull-up on
  output logic      [`GPPS_PW-1:0] pa_dig_en_o,  // Port A input buffer on
  input  wire logic [`GPPS_PW-1:0] pc_in_i,      // Port C pin levels
  output logic      [`GPPS_PW-1:0] pc_out_o,     // Port C output value
  output logic      [`GPPS_PW-1:0] pc_oe_o,      // Port C drive enable
  input  wire logic                tx_d_i,       // Serial tx data
  input  wire logic                tx_en_i,      // Serial tx enabled
  input  wire logic                sdo_d_i,      // SPI data out
  input  wire logic                sdo_en_i,     // SPI data out enabled
  input  wire logic                pwmb_d_i,     // PWM B data
  input  wire logic                pwmb_en_i,    // PWM B enabled
  input  wire logic                ccpa_d_i,     // Capture/PWM A data
  input  wire logic                ccpa_en_i,    // Capture/PWM A enabled
  output logic                     timer_gate_o, // Timer gate input
  output logic                     rx_o,         // Serial rx input
  output logic                     ss_o          // Slave select input
);
  ////////////////////////////////////////////////////////////////////////
  localparam gpps_state_t RST_ST = '{
    dir_a: `GPPS_DIR_RST,
    lat_a: `GPPS_LAT_RST,
    ans_a: `GPPS_ANS_RST,
    wpu_a: `GPPS_WPU_RST,
    dir_c: `GPPS_DIR_RST,
    lat_c: `GPPS_LAT_RST,
    apf:   `GPPS_APF_RST,
    ack:   1'b0,
    rdat:  8'h00
  };

  gpps_state_t         st_r;
  gpps_state_t         st_nxt;
  gpps_reg_t           reg_sel;
  logic                req;
  logic                wr_go;
  logic [`GPPS_PW-1:0] sync_a;
  logic [`GPPS_PW-1:0] sync_c;
  logic [`GPPS_PW-1:0] lvl_a;
  logic [`GPPS_PW-1:0] lvl_c;
  logic [`GPPS_PW-1:0] ovr_a;
  logic [`GPPS_PW-1:0] val_a;
  logic [`GPPS_PW-1:0] ovr_c;
  logic [`GPPS_PW-1:0] val_c;
  logic [`GPPS_PW-1:0] wdat;
  logic [`GPPS_PW-1:0] new_lat_a;
  logic [`GPPS_PW-1:0] new_lat_c;

  ////////////////////////////////////////////////////////////////////////
  gpps_sync #(
    .W (`GPPS_PW)
  ) u_sync_a (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (pa_in_i),
    .q_o   (sync_a)
  );

  gpps_sync #(
    .W (`GPPS_PW)
  ) u_sync_c (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (pc_in_i),
    .q_o   (sync_c)
  );

  // Analog pins read zero digitally
  assign lvl_a = sync_a & ~st_r.ans_a; // RULE18
  assign lvl_c = LARGE_PKG ? sync_c : '0; // RULE2

  gpps_pin_mux #(
    .LARGE_PKG (LARGE_PKG)
  ) u_mux (
    .apf_i     (st_r.apf),
    .tx_d_i    (tx_d_i),
    .tx_en_i   (tx_en_i),
    .sdo_d_i   (sdo_d_i),
    .sdo_en_i  (sdo_en_i),
    .pwmb_d_i  (pwmb_d_i),
    .pwmb_en_i (pwmb_en_i),
    .ccpa_d_i  (ccpa_d_i),
    .ccpa_en_i (ccpa_en_i),
    .lvl_a_i   (lvl_a),
    .lvl_c_i   (lvl_c),
    .ovr_a_o   (ovr_a),
    .val_a_o   (val_a),
    .ovr_c_o   (ovr_c),
    .val_c_o   (val_c),
    .gate_o    (timer_gate_o),
    .rx_o      (rx_o),
    .ss_o      (ss_o)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic gpps_reg_t decode(input logic [7:0] adr);
    case (adr)
      `GPPS_ADR_A_LEVEL: decode = GPPS_R_A_LEVEL; // RULE1
      `GPPS_ADR_A_LATCH: decode = GPPS_R_A_LATCH;
      `GPPS_ADR_A_DIR:   decode = GPPS_R_A_DIR;
      `GPPS_ADR_A_ANSEL: decode = GPPS_R_A_ANSEL;
      `GPPS_ADR_A_PULL:  decode = GPPS_R_A_PULL;
      `GPPS_ADR_APF:     decode = GPPS_R_APF;
      `GPPS_ADR_C_LEVEL: decode = GPPS_R_C_LEVEL;
      `GPPS_ADR_C_LATCH: decode = GPPS_R_C_LATCH;
      `GPPS_ADR_C_DIR:   decode = GPPS_R_C_DIR;
      default:           decode = GPPS_R_NONE;
    endcase
  endfunction

  assign reg_sel = decode(wb_adr_i);
  assign req     = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master samples ack
  assign wr_go   = req & wb_we_i & st_r.ack;
  assign wdat    = wb_dat_i[`GPPS_PW-1:0];
  // Without the low byte lane the pins are read back unmodified
  assign new_lat_a = (wb_sel_i[0] ? wdat : lvl_a) & `GPPS_LAT_A_MASK; // RULE15
  assign new_lat_c = (wb_sel_i[0] ? wdat : lvl_c) & `GPPS_C_MASK;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = req & ~st_r.ack;
    unique case (reg_sel)
      GPPS_R_A_LEVEL: st_nxt.rdat = {2'b00, lvl_a}; // RULE4
      GPPS_R_A_LATCH: st_nxt.rdat = {2'b00, st_r.lat_a}; // RULE4
      GPPS_R_A_DIR:   st_nxt.rdat = {2'b00, st_r.dir_a};
      GPPS_R_A_ANSEL: st_nxt.rdat = {2'b00, st_r.ans_a};
      GPPS_R_A_PULL:  st_nxt.rdat = {2'b00, st_r.wpu_a};
      GPPS_R_APF:     st_nxt.rdat = st_r.apf; // RULE8
      GPPS_R_C_LEVEL: st_nxt.rdat = {2'b00, lvl_c};
      GPPS_R_C_LATCH: st_nxt.rdat = {2'b00, st_r.lat_c};
      GPPS_R_C_DIR:   st_nxt.rdat = LARGE_PKG ? {2'b00, st_r.dir_c} : 8'h00;
      GPPS_R_NONE:    st_nxt.rdat = 8'h00;
    endcase
    if (wr_go) begin
      unique case (reg_sel)
        GPPS_R_A_LEVEL,
        GPPS_R_A_LATCH: st_nxt.lat_a = new_lat_a; // RULE3
        GPPS_R_A_DIR: begin
          if (wb_sel_i[0]) begin
            st_nxt.dir_a = (wdat & `GPPS_DIR_A_MASK)
                           | `GPPS_DIR_A_FIXED; // RULE14
          end
        end
        GPPS_R_A_ANSEL: begin
          if (wb_sel_i[0]) begin
            st_nxt.ans_a = wdat & `GPPS_ANS_A_MASK; // RULE24
          end
        end
        GPPS_R_A_PULL: begin
          if (wb_sel_i[0]) begin
            st_nxt.wpu_a = wdat & `GPPS_WPU_MASK;
          end
        end
        GPPS_R_APF: begin
          if (wb_sel_i[0]) begin
            st_nxt.apf = wb_dat_i[7:0] & `GPPS_APF_MASK; // RULE8
          end
        end
        GPPS_R_C_LEVEL,
        GPPS_R_C_LATCH: begin
          if (LARGE_PKG) begin
            st_nxt.lat_c = new_lat_c; // RULE3
          end
        end
        GPPS_R_C_DIR: begin
          if (LARGE_PKG && wb_sel_i[0]) begin
            st_nxt.dir_c = wdat & `GPPS_C_MASK;
          end
        end
        GPPS_R_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= RST_ST; // RULE23
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = {24'h00_0000, st_r.rdat};

  ////////////////////////////////////////////////////////////////////////
  // Direction alone gates the driver; analog select is ignored here
  assign pa_oe_o     = ~st_r.dir_a & ~`GPPS_DIR_A_FIXED; // RULE13 RULE16
  assign pa_out_o    = (ovr_a & val_a) | (~ovr_a & st_r.lat_a); // RULE6
  assign pa_pullup_o = st_r.wpu_a & st_r.dir_a; // RULE22
  assign pa_dig_en_o = ~st_r.ans_a; // RULE5
  assign pc_oe_o     = LARGE_PKG ? ~st_r.dir_c : '0; // RULE2
  assign pc_out_o    = LARGE_PKG ? ((ovr_c & val_c) | (~ovr_c & st_r.lat_c))
                                 : '0;

  ////////////////////////////////////////////////////////////////////////
  chk_a3_no_drive: assert property ( // RULE14
    @(posedge clk_i) disable iff (rst_i)
    !pa_oe_o[`GPPS_P3] && st_r.dir_a[`GPPS_P3])
    else $error("pin A3 driven or its direction bit cleared");

  chk_reset_inputs: assert property ( // RULE23
    @(posedge clk_i)
    $past(rst_i) |-> (pa_oe_o == '0) && (st_r.dir_a == `GPPS_DIR_RST))
    else $error("drivers not off after reset");

  chk_ack_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && ce_i) |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  chk_analog_reads_zero: assert property ( // RULE18
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && !wb_we_i && reg_sel == GPPS_R_A_LEVEL)
      |-> (wb_dat_o[`GPPS_PW-1:0] & st_r.ans_a) == '0)
    else $error("analog pin read nonzero");

  chk_analog_still_drives: assert property ( // RULE19
    @(posedge clk_i) disable iff (rst_i)
    (st_r.ans_a[`GPPS_P0] && !st_r.dir_a[`GPPS_P0] && !ovr_a[`GPPS_P0])
      |-> pa_oe_o[`GPPS_P0] && pa_out_o[`GPPS_P0] == st_r.lat_a[`GPPS_P0])
    else $error("analog select blocked digital output");

  chk_level_write_latch: assert property ( // RULE3
    @(posedge clk_i) disable iff (rst_i)
    (wr_go && ce_i && wb_sel_i[0] && reg_sel == GPPS_R_A_LEVEL)
      |=> st_r.lat_a == ($past(wdat) & `GPPS_LAT_A_MASK))
    else $error("pin-level write did not reach the latch");

  chk_apf_bit4_zero: assert property ( // RULE8
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && !wb_we_i && reg_sel == GPPS_R_APF) |-> !wb_dat_o[4])
    else $error("steering bit 4 read as one");

  chk_gate_route: assert property ( // RULE9
    @(posedge clk_i) disable iff (rst_i)
    timer_gate_o == (st_r.apf[`GPPS_APF_GATE] ? lvl_a[`GPPS_P3]
                                             : lvl_a[`GPPS_P4]))
    else $error("timer gate taken from wrong pin");

  chk_pwmb_small: assert property ( // RULE10
    @(posedge clk_i) disable iff (rst_i)
    (!LARGE_PKG && pwmb_en_i && !tx_en_i && !sdo_en_i)
      |-> (st_r.apf[`GPPS_APF_PWMB] ? pa_out_o[`GPPS_P4]
                                    : pa_out_o[`GPPS_P0]) == pwmb_d_i)
    else $error("PWM B on wrong pin");

  chk_pwmb_large: assert property ( // RULE11
    @(posedge clk_i) disable iff (rst_i)
    (LARGE_PKG && pwmb_en_i && !tx_en_i)
      |-> pc_out_o[`GPPS_P4] == pwmb_d_i && !ovr_a[`GPPS_P0])
    else $error("PWM B not fixed on C4");

  chk_pullup_output: assert property ( // RULE22
    @(posedge clk_i) disable iff (rst_i)
    (pa_pullup_o & pa_oe_o) == '0)
    else $error("pull-up on an output pin");

  chk_steer_keeps_dir: assert property ( // RULE7
    @(posedge clk_i) disable iff (rst_i)
    (wr_go && reg_sel == GPPS_R_APF) |=> $stable(st_r.dir_a))
    else $error("steering write changed direction");

  chk_ce_freeze: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(st_r))
    else $error("state moved with clock enable low");
endmodule
`default_nettype wire

// file: core/gpps_dummy_never.sv
`default_nettype none
`default_nettype wire

// file: verif/gpps_pins.sv
`default_nettype none
module gpps_pins (
  input  wire logic       clk_i,    // System clock
  input  wire logic [5:0] out_i,    // Device output value
  input  wire logic [5:0] oe_i,     // Device drive enable
  input  wire logic [5:0] pull_i,   // Device pull-up on
  input  wire logic [5:0] ext_en_i, // External driver on
  input  wire logic [5:0] ext_i,    // External driver level
  output logic      [5:0] pin_o     // Resolved pin level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] float_r = 6'h15;
  // Floating pins wander, so a stale level never passes for a real one
  always_ff @(posedge clk_i) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (oe_i[i]) pin_o[i] = out_i[i];
      else if (ext_en_i[i]) pin_o[i] = ext_i[i];
      else if (pull_i[i]) pin_o[i] = 1'b1;
      else pin_o[i] = float_r[i];
    end
  end
endmodule
`default_nettype wire

// file: verif/gpps_port_with_pin_steering_tb.sv
`default_nettype none
`include "gpps_consts.svh"
module gpps_port_with_pin_steering_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, dat_o;
  logic        ack, tgate, rx, ss;
  logic        ce = 1'b1;
  logic [5:0]  pin, p_out, p_oe, p_pull, p_dig, pc_oe, pc_out, pc_out_l;
  logic [5:0]  ext = 6'h00;
  logic [5:0]  ext_en = 6'h3F;
  // Peripheral pairs: tx, sdo, pwm b, capture/pwm a; data then enable
  logic [7:0]  per = 8'h00;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cycles = 0;

  gpps_port dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pa_in_i(pin), .pa_out_o(p_out), .pa_oe_o(p_oe),
    .pa_pullup_o(p_pull), .pa_dig_en_o(p_dig), .pc_in_i(6'h00),
    .pc_out_o(pc_out), .pc_oe_o(pc_oe), .tx_d_i(per[0]), .tx_en_i(per[1]),
    .sdo_d_i(per[2]), .sdo_en_i(per[3]), .pwmb_d_i(per[4]),
    .pwmb_en_i(per[5]), .ccpa_d_i(per[6]), .ccpa_en_i(per[7]),
    .timer_gate_o(tgate), .rx_o(rx), .ss_o(ss));

  // Large package copy on the same bus, watched only on port C
  gpps_port #(.LARGE_PKG(1'b1)) dut_large (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(),
    .wb_ack_o(), .pa_in_i(pin), .pa_out_o(), .pa_oe_o(), .pa_pullup_o(),
    .pa_dig_en_o(), .pc_in_i(6'h00), .pc_out_o(pc_out_l), .pc_oe_o(),
    .tx_d_i(per[0]), .tx_en_i(per[1]), .sdo_d_i(per[2]),
    .sdo_en_i(per[3]), .pwmb_d_i(per[4]), .pwmb_en_i(per[5]),
    .ccpa_d_i(per[6]), .ccpa_en_i(per[7]), .timer_gate_o(), .rx_o(),
    .ss_o());

  gpps_pins pins (.clk_i(clk_i), .out_i(p_out), .oe_i(p_oe),
    .pull_i(p_pull), .ext_en_i(ext_en), .ext_i(ext), .pin_o(pin));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // Generous ceiling: the whole run needs under two hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic cycle; returns one edge after release so outputs are settled
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [3:0] s, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, 4'h1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    wb(a, 1'b0, 4'h1, 32'h0000_0000);
    chk(nm, e, rdat);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`GPPS_ADR_A_DIR, 32'h0000_003F, "dir reset");
    rd(`GPPS_ADR_A_LATCH, 32'h0000_0000, "latch reset");
    rd(`GPPS_ADR_A_ANSEL, 32'h0000_0017, "analog reset");
    rd(`GPPS_ADR_APF, 32'h0000_0000, "steer reset");
    chk("oe reset", 32'h0000_0000, {26'h0, p_oe});
    chk("port c oe", 32'h0000_0000, {26'h0, pc_oe});
    wr(`GPPS_ADR_A_DIR, 32'h0000_0000);
    rd(`GPPS_ADR_A_DIR, 32'h0000_0008, "dir a3");
    chk("oe drive", 32'h0000_0037, {26'h0, p_oe});
    wr(`GPPS_ADR_A_LATCH, 32'h0000_00FF);
    rd(`GPPS_ADR_A_LATCH, 32'h0000_0037, "latch bits");
    chk("out latch", 32'h0000_0037, {26'h0, p_out});
    wr(`GPPS_ADR_A_LEVEL, 32'h0000_0015);
    rd(`GPPS_ADR_A_LATCH, 32'h0000_0015, "level write");
    $display("test direction and latch done");

    wr(`GPPS_ADR_A_DIR, 32'h0000_003F);
    wr(`GPPS_ADR_A_ANSEL, 32'h0000_0000);
    ext <= 6'h2A;
    repeat (4) @(posedge clk_i);
    rd(`GPPS_ADR_A_LEVEL, 32'h0000_002A, "pin level");
    rd(`GPPS_ADR_A_LATCH, 32'h0000_0015, "latch held");
    wr(`GPPS_ADR_A_ANSEL, 32'h0000_0017);
    rd(`GPPS_ADR_A_LEVEL, 32'h0000_0028, "analog read");
    chk("buffer off", 32'h0000_0028, {26'h0, p_dig});
    wr(`GPPS_ADR_A_ANSEL, 32'h0000_0000);
    wb(`GPPS_ADR_A_LEVEL, 1'b1, 4'h0, 32'h0000_0000);
    rd(`GPPS_ADR_A_LATCH, 32'h0000_0022, "rmw latch");
    wr(`GPPS_ADR_A_LATCH, 32'h0000_0015);
    wr(`GPPS_ADR_A_ANSEL, 32'h0000_0017);
    wr(`GPPS_ADR_A_DIR, 32'h0000_0000);
    chk("analog oe", 32'h0000_0037, {26'h0, p_oe});
    chk("analog out", 32'h0000_0015, {26'h0, p_out});
    wr(`GPPS_ADR_A_DIR, 32'h0000_003F);
    wr(`GPPS_ADR_A_ANSEL, 32'h0000_0000);
    $display("test levels and analog done");

    wr(`GPPS_ADR_APF, 32'h0000_00FF);
    rd(`GPPS_ADR_APF, 32'h0000_00EF, "steer bit4");
    wr(`GPPS_ADR_APF, 32'h0000_0000);
    ext <= 6'h0A;
    repeat (4) @(posedge clk_i);
    chk("gate a4", 32'h0000_0000, {31'h0, tgate});
    wr(`GPPS_ADR_APF, 32'h0000_0008);
    chk("gate a3", 32'h0000_0001, {31'h0, tgate});
    chk("rx a1 ss a3", 32'h0000_0003, {30'h0, rx, ss});
    wr(`GPPS_ADR_APF, 32'h0000_00A8);
    chk("rx a5 ss a0", 32'h0000_0000, {30'h0, rx, ss});
    // Clock enable low must hold the synchronisers too
    ce <= 1'b0;
    ext <= 6'h02;
    repeat (4) @(posedge clk_i);
    chk("frozen gate", 32'h0000_0001, {31'h0, tgate});
    ce <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("thawed gate", 32'h0000_0000, {31'h0, tgate});
    wr(`GPPS_ADR_A_LATCH, 32'h0000_0000);
    wr(`GPPS_ADR_A_DIR, 32'h0000_0000);
    per <= 8'h30;
    wr(`GPPS_ADR_APF, 32'h0000_0000);
    chk("pwm b a0", 32'h0000_0001, {26'h0, p_out});
    chk("small c out", 32'h0000_0000, {26'h0, pc_out});
    chk("pwm b c4", 32'h0000_0010, {26'h0, pc_out_l});
    wr(`GPPS_ADR_APF, 32'h0000_0002);
    chk("pwm b a4", 32'h0000_0010, {26'h0, p_out});
    rd(`GPPS_ADR_A_DIR, 32'h0000_0008, "dir kept");
    chk("oe kept", 32'h0000_0037, {26'h0, p_oe});
    per <= 8'h32;
    wr(`GPPS_ADR_APF, 32'h0000_0000);
    chk("tx wins a0", 32'h0000_0000, {26'h0, p_out});
    per <= 8'hC0;
    wr(`GPPS_ADR_APF, 32'h0000_0000);
    chk("ccp a2", 32'h0000_0004, {26'h0, p_out});
    wr(`GPPS_ADR_APF, 32'h0000_0001);
    chk("ccp a5", 32'h0000_0020, {26'h0, p_out});
    chk("ccp c5", 32'h0000_0020, {26'h0, pc_out_l});
    per <= 8'h00;
    $display("test steering done");

    wr(`GPPS_ADR_A_DIR, 32'h0000_0030);
    chk("pull inputs", 32'h0000_0038, {26'h0, p_pull});
    wr(`GPPS_ADR_A_PULL, 32'h0000_000F);
    chk("pull reg", 32'h0000_0008, {26'h0, p_pull});
    rd(8'h30, 32'h0000_0000, "unmapped");
    $display("test pull-up and map done");
    test_done();
  end
endmodule
`default_nettype wire
